// ---- verilog/bus_cfg_pkg.sv ----
// Shared constants and types for the strap-configured display controller
// host port and for the chip-select bus master that drives it.
// Assumes both ends share one bus clock and import this package whole.
//
// How it works
// - Latch five straps and bus-start at reset release
// - Strap code picks host bus type
// - Byte-order strap: low little, high big endian
// - Panel-power strap sets panel power polarity
// - Wait seen by host is active high
// - 64K window: 40K buffer, top 32 bytes registers
// - Host places window base at 40 0000h
// - Host treats device as 16-bit port
// - Host compares only upper ten address bits
// - Select follows address by one clock
// - Bursts inhibited: one bus cycle per access
// - Cycle ends on acknowledge derived from wait
// - No parity, write protect or address type
// - Revision register read is side-effect free
// - Wait held until data ready or accepted
// - Host drives separate low and high write strobes
package bus_cfg_pkg;

    // Device address map, byte addresses on the 16-bit port
    localparam logic [15:0] BUFFER_BYTES   = 16'ha000;
    localparam int          BUFFER_WORDS   = 20480;
    localparam logic [15:0] REG_BASE       = 16'hffe0;
    localparam int          REG_COUNT      = 32;
    localparam logic [4:0]  REVISION_INDEX = 5'h00;
    localparam logic [4:0]  PANEL_INDEX    = 5'h03;
    localparam int          PANEL_ON_BIT   = 0;

    // Display refresh steals the memory for a slice of every period
    localparam int          REFRESH_PERIOD = 16;
    localparam int          REFRESH_LEN    = 3;

    // Host chip-select setup
    localparam logic [31:0] host_window_base     = 32'h0040_0000;
    localparam logic [31:0] address_compare_mask = 32'hffc0_0000;
    localparam int          port_width_field     = 16;

    // Controller registers on AXI4-Lite
    localparam logic [3:0]  TARGET_OFFSET = 4'h0;
    localparam logic [3:0]  WDATA_OFFSET  = 4'h4;
    localparam logic [3:0]  CTRL_OFFSET   = 4'h8;
    localparam logic [3:0]  STATUS_OFFSET = 4'hc;
    localparam int          CTRL_GO       = 0;
    localparam int          CTRL_WRITE    = 1;
    localparam int          CTRL_LANE_LO  = 2;
    localparam int          CTRL_LANE_HI  = 3;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_DONE     = 1;
    localparam int          STAT_MISS     = 2;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    // Host bus type picked by the straps
    typedef enum logic [2:0] {
        mode_generic_one = 3'b000,
        mode_generic_two = 3'b001,
        mode_word_a      = 3'b010,
        mode_word_b      = 3'b011,
        mode_fast_a      = 3'b100,
        mode_fast_b      = 3'b101,
        mode_reserved    = 3'b111
    } bus_mode_t;

    typedef enum logic [1:0] {
        dev_idle = 2'b00,
        dev_wait = 2'b01,
        dev_done = 2'b10
    } dev_state_t;

    typedef enum logic [1:0] {
        host_idle   = 2'b00,
        host_addr   = 2'b01,
        host_select = 2'b10
    } host_state_t;

endpackage

// ---- verilog/host_bus_if.sv ----
// Carrier for the 16-bit chip-select bus between host and device.
// Assumes both ends run on the same bus clock; the data pins are split
// into host and device drive, the device enable is low while driving.
`timescale 1ns/10ps
`default_nettype none
interface host_bus_if;
    logic [15:0] addr;
    logic [15:0] host_data;
    logic [15:0] dev_data;
    logic        dev_data_oe_n;
    logic        chip_select_n;
    logic        low_byte_write_n;
    logic        high_byte_write_n;
    logic        read_n;
    logic        wait_high;

    modport device (
        input  addr, host_data, chip_select_n, low_byte_write_n,
        input  high_byte_write_n, read_n,
        output dev_data, dev_data_oe_n, wait_high
    );
    modport host (
        output addr, host_data, chip_select_n, low_byte_write_n,
        output high_byte_write_n, read_n,
        input  dev_data, dev_data_oe_n, wait_high
    );
endinterface
`default_nettype wire

// ---- verilog/lcd_bus_device.sv ----
// Device end: strap capture, host bus decode, display buffer and
// control registers, wait generation against display refresh.
// Assumes the host shares aclk and holds select until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module lcd_bus_device
    import bus_cfg_pkg::*;
#(
    // Arbitrary revision value, names no real part
    parameter logic [7:0] REVISION = 8'h5a
) (
    // Clock, reset, enable
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire logic      clk_en,
    // Configuration straps
    input  wire logic      bus_select_strap_a,
    input  wire logic      bus_select_strap_b,
    input  wire logic      bus_select_strap_c,
    input  wire logic      byte_order_strap,
    input  wire logic      panel_power_polarity_strap,
    input  wire logic      bus_start_strap_n,
    // Host bus
    host_bus_if.device     bus,
    // Configuration and panel
    output logic           panel_power_control,
    output logic           config_valid,
    output bus_mode_t      host_bus_mode,
    output logic           big_endian
);

    logic [5:0]  strap_meta;
    logic [5:0]  strap_sync;
    logic        captured;
    logic [3:0]  bus_code;
    logic        order_cfg;
    logic        power_pol;
    logic [3:0]  refresh_cnt;
    dev_state_t  state;
    dev_state_t  next_state;
    logic [15:0] rdata_q;
    logic        read_q;
    logic [7:0]  regs [0:REG_COUNT-1];
    logic [15:0] mem  [0:BUFFER_WORDS-1];

    // Straps are pins, so two flops before the capture looks at them
    always_ff @(posedge aclk) begin
        if (clk_en) begin
            strap_meta <= {bus_select_strap_c, bus_select_strap_b,
                           bus_select_strap_a, bus_start_strap_n,
                           byte_order_strap, panel_power_polarity_strap};
            strap_sync <= strap_meta;
        end
    end

    // Capture once at the first enabled edge after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            captured  <= 1'b0;
            bus_code  <= 4'h0;
            order_cfg <= 1'b0;
            power_pol <= 1'b0;
        end else if (clk_en && !captured) begin
            captured  <= 1'b1;
            bus_code  <= strap_sync[5:2];
            order_cfg <= strap_sync[1];
            power_pol <= strap_sync[0];
        end
    end

    // Bus type from {c, b, a, bus-start}; bus-start only matters on 111
    wire bus_is_111 = (bus_code[3:1] == 3'b111);
    wire bus_is_011 = (bus_code[3:1] == 3'b011);
    wire bus_is_101 = (bus_code[3:1] == 3'b101);
    wire bus_is_000 = (bus_code[3:1] == 3'b000);
    wire bus_is_001 = (bus_code[3:1] == 3'b001);
    assign host_bus_mode =
        !captured  ? mode_reserved :
        bus_is_111 ? (bus_code[0] ? mode_generic_two : mode_generic_one) :
        bus_is_011 ? mode_word_a :
        bus_is_101 ? mode_word_b :
        bus_is_000 ? mode_fast_a :
        bus_is_001 ? mode_fast_b : mode_reserved;
    // Reserved codes leave the port dead: cycles never finish
    assign config_valid = (host_bus_mode != mode_reserved);
    assign big_endian   = order_cfg;

    // Panel power: enable bit driven at the strapped polarity
    wire panel_on = regs[PANEL_INDEX][PANEL_ON_BIT];
    assign panel_power_control = power_pol ? panel_on : ~panel_on;

    // Refresh slice counter; host waits while it owns the memory
    wire refresh_busy = (refresh_cnt < 4'(REFRESH_LEN));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refresh_cnt <= 4'h0;
        end else if (clk_en) begin
            refresh_cnt <= (refresh_cnt == 4'(REFRESH_PERIOD - 1)) ?
                           4'h0 : refresh_cnt + 4'h1;
        end
    end

    // Host cycle decode; big endian puts the even byte on the high lane
    wire cs_active = ~bus.chip_select_n;
    wire rd_req    = ~bus.read_n;
    wire wr_lo     = order_cfg ? ~bus.high_byte_write_n
                               : ~bus.low_byte_write_n;
    wire wr_hi     = order_cfg ? ~bus.low_byte_write_n
                               : ~bus.high_byte_write_n;
    wire [15:0] wdata_le = order_cfg ?
                           {bus.host_data[7:0], bus.host_data[15:8]} :
                           bus.host_data;
    wire        in_buffer = (bus.addr < BUFFER_BYTES);
    wire        in_regs   = (bus.addr >= REG_BASE);
    wire [14:0] word_idx  = bus.addr[15:1];
    wire [4:0]  reg_lo    = {bus.addr[4:1], 1'b0};
    wire [4:0]  reg_hi    = {bus.addr[4:1], 1'b1};
    wire        request   = cs_active && (rd_req || wr_lo || wr_hi);
    wire        perform   = (state == dev_wait) && !refresh_busy;
    // Revision comes from a constant, so reading it changes nothing
    wire [7:0]  reg_lo_rd = (reg_lo == REVISION_INDEX) ?
                            REVISION : regs[reg_lo];
    wire [15:0] rd_word   = in_buffer ? mem[word_idx] :
                            in_regs   ? {regs[reg_hi], reg_lo_rd} :
                            16'h0000;

    // Access state
    always_comb begin
        next_state = state;
        case (state)
            dev_idle: begin
                if (request && config_valid) begin
                    next_state = dev_wait;
                end
            end
            dev_wait: begin
                if (!cs_active) begin
                    next_state = dev_idle;
                end else if (perform) begin
                    next_state = dev_done;
                end
            end
            dev_done: begin
                if (!cs_active) begin
                    next_state = dev_idle;
                end
            end
            default: begin
                next_state = dev_idle;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= dev_idle;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Read data is latched when the slot is won and held to cycle end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 16'h0000;
            read_q  <= 1'b0;
        end else if (clk_en && perform) begin
            rdata_q <= order_cfg ? {rd_word[7:0], rd_word[15:8]}
                                 : rd_word;
            read_q  <= rd_req;
        end
    end

    // Buffer writes per byte lane; no reset, contents are display data
    always_ff @(posedge aclk) begin
        if (clk_en && perform && in_buffer) begin
            if (wr_lo) begin
                mem[word_idx][7:0]  <= wdata_le[7:0];
            end
            if (wr_hi) begin
                mem[word_idx][15:8] <= wdata_le[15:8];
            end
        end
    end

    // Control registers; the revision slot is never written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (clk_en && perform && in_regs) begin
            if (wr_lo && reg_lo != REVISION_INDEX) begin
                regs[reg_lo] <= wdata_le[7:0];
            end
            if (wr_hi) begin
                regs[reg_hi] <= wdata_le[15:8];
            end
        end
    end

    // Wait is active high here and drops only once the access is done
    assign bus.wait_high     = cs_active && (state != dev_done);
    assign bus.dev_data      = rdata_q;
    assign bus.dev_data_oe_n = ~(cs_active && (state == dev_done) && read_q);

endmodule
`default_nettype wire

// ---- verilog/chip_select_host.sv ----
// Host end: AXI4-Lite command registers and a single-cycle chip-select
// bus master with externally acknowledged cycles.
// Assumes the device shares aclk and answers every selected cycle.
`timescale 1ns/10ps
`default_nettype none
module chip_select_host
    import bus_cfg_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // AXI4-Lite write channels
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Device bus
    host_bus_if.host         bus
);

    logic [31:0] target;
    logic [15:0] wr_value;
    logic [3:0]  ctrl;
    logic [15:0] rd_value;
    logic        done;
    logic        miss;
    logic        aw_held;
    logic        w_held;
    logic        aw_out;
    logic [3:0]  aw_off;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    host_state_t state;

    // Byte-lane merge for AXI strobes
    wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                             {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire        busy      = (state != host_idle);
    wire        wr_fire   = aw_held && w_held && !bvalid;
    // Only the first three words decode; higher addresses must not alias
    wire        off_ok    = !aw_out && ((aw_off == TARGET_OFFSET) ||
                            (aw_off == WDATA_OFFSET) ||
                            (aw_off == CTRL_OFFSET));
    wire        go        = wr_fire && off_ok && aw_off == CTRL_OFFSET &&
                            w_strb[0] && w_data[CTRL_GO] && !busy;
    // Only the top ten address bits pick the device window
    wire        hit       = ((target & address_compare_mask) ==
                             host_window_base);
    // Inverter gated by select turns device wait into acknowledge
    wire        cycle_acknowledge_n = bus.chip_select_n | bus.wait_high;

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;

    // AXI write side: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_out   <= 1'b0;
            aw_off   <= 4'h0;
            w_data   <= 32'h0;
            w_strb   <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
            target   <= 32'h0;
            wr_value <= 16'h0;
            ctrl     <= 4'h0;
        end else if (clk_en) begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_off  <= awaddr[3:0];
                aw_out  <= (awaddr[31:4] != 28'h0);
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= off_ok ? RESP_OKAY : RESP_SLVERR;
                if (!aw_out && aw_off == TARGET_OFFSET) begin
                    target <= (target & ~strb_mask) | (w_data & strb_mask);
                end
                if (!aw_out && aw_off == WDATA_OFFSET) begin
                    wr_value <= 16'((wr_value & ~strb_mask[15:0]) |
                                    (w_data[15:0] & strb_mask[15:0]));
                end
                if (!aw_out && aw_off == CTRL_OFFSET && w_strb[0] &&
                    !busy) begin
                    ctrl <= {w_data[3:1], 1'b0};
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI read side; only the first four words answer
    wire        ar_in  = (araddr[31:4] == 28'h0);
    wire [31:0] status_word = {rd_value, 13'h0, miss, done, busy};
    wire [31:0] rd_mux =
        !ar_in                         ? 32'h0 :
        (araddr[3:0] == TARGET_OFFSET) ? target :
        (araddr[3:0] == WDATA_OFFSET)  ? {16'h0, wr_value} :
        (araddr[3:0] == CTRL_OFFSET)   ? {28'h0, ctrl} :
        (araddr[3:0] == STATUS_OFFSET) ? status_word : 32'h0;
    wire        rd_ok  = (araddr[3:0] == TARGET_OFFSET) ||
                         (araddr[3:0] == WDATA_OFFSET) ||
                         (araddr[3:0] == CTRL_OFFSET) ||
                         (araddr[3:0] == STATUS_OFFSET);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_mux;
                rresp  <= (rd_ok && ar_in) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // One bus cycle per command, bursts never issued
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state                 <= host_idle;
            done                  <= 1'b0;
            miss                  <= 1'b0;
            rd_value              <= 16'h0;
            bus.addr              <= 16'h0;
            bus.host_data         <= 16'h0;
            bus.chip_select_n     <= 1'b1;
            bus.read_n            <= 1'b1;
            bus.low_byte_write_n  <= 1'b1;
            bus.high_byte_write_n <= 1'b1;
        end else if (clk_en) begin
            case (state)
                host_idle: begin
                    if (go) begin
                        done <= 1'b0;
                        miss <= !hit;
                        if (hit) begin
                            state         <= host_addr;
                            bus.addr      <= target[15:0];
                            bus.host_data <= wr_value;
                        end
                    end
                end
                host_addr: begin
                    // Select lags the address lines by one edge
                    state                 <= host_select;
                    bus.chip_select_n     <= 1'b0;
                    bus.read_n            <= ctrl[CTRL_WRITE];
                    bus.low_byte_write_n  <= !(ctrl[CTRL_WRITE] &&
                                               ctrl[CTRL_LANE_LO]);
                    bus.high_byte_write_n <= !(ctrl[CTRL_WRITE] &&
                                               ctrl[CTRL_LANE_HI]);
                end
                host_select: begin
                    // Wait count is unused; the device ends the cycle
                    if (!cycle_acknowledge_n) begin
                        state                 <= host_idle;
                        done                  <= 1'b1;
                        rd_value              <= bus.dev_data;
                        bus.chip_select_n     <= 1'b1;
                        bus.read_n            <= 1'b1;
                        bus.low_byte_write_n  <= 1'b1;
                        bus.high_byte_write_n <= 1'b1;
                    end
                end
                default: begin
                    state <= host_idle;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- bench/host_bus_props.sv ----
// Checker for the chip-select bus between host and device ends.
// Assumes one shared clock; sees only the interface signals.
`timescale 1ns/10ps
`default_nettype none
module host_bus_props (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus signals
    input wire logic [15:0] addr,
    input wire logic [15:0] host_data,
    input wire logic        dev_data_oe_n,
    input wire logic        chip_select_n,
    input wire logic        low_byte_write_n,
    input wire logic        high_byte_write_n,
    input wire logic        read_n,
    input wire logic        wait_high
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Wait is active high and only inside a selected cycle
    property p_wait_sel; chip_select_n |-> !wait_high; endproperty
    a_wait_sel: assert property (p_wait_sel)
        else $error("wait high while unselected");
    property p_wait_start; $fell(chip_select_n) |-> wait_high; endproperty
    a_wait_start: assert property (p_wait_start)
        else $error("no wait at select");
    // Refresh slot is short, so the device must end the cycle soon
    property p_wait_end;
        $fell(chip_select_n) |-> ##[1:8] !wait_high;
    endproperty
    a_wait_end: assert property (p_wait_end)
        else $error("cycle never acknowledged");
    property p_ack_end;
        !chip_select_n && !wait_high |=> chip_select_n && read_n
            && low_byte_write_n && high_byte_write_n;
    endproperty
    a_ack_end: assert property (p_ack_end)
        else $error("cycle not ended on acknowledge");
    property p_single; $rose(chip_select_n) |=> chip_select_n; endproperty
    a_single: assert property (p_single)
        else $error("back to back select");
    // Address and data settle before select and hold through it
    property p_addr_hold;
        !chip_select_n |-> $stable(addr) && $stable(host_data);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved while selected");
    property p_read_drive;
        !dev_data_oe_n |-> !chip_select_n && !read_n && !wait_high;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("device drives outside read data phase");
    property p_strobes;
        !read_n |-> low_byte_write_n && high_byte_write_n;
    endproperty
    a_strobes: assert property (p_strobes)
        else $error("read and write strobes together");
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Testbench joining host and device ends through the bus carrier.
// Assumes AXI4-Lite access to host registers, bready/rready held high.
`timescale 1ns/10ps
`default_nettype none
module tb
    import bus_cfg_pkg::*;
();
    // Arbitrary revision value, names no real part
    localparam logic [7:0] REV = 8'hc3;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [4:0]  straps = 5'h07;
    logic        bs_n = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic        awvalid = 0, wvalid = 0, arvalid = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        ppc, cfg_ok, big_endian;
    bus_mode_t   hmode;
    int          miscompares = 0;
    int          compares = 0;

    // Design ends and checker
    host_bus_if host_bus_if_i ();
    lcd_bus_device #(.REVISION(REV)) lcd_bus_device_i (
        .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .bus_select_strap_a(straps[0]), .bus_select_strap_b(straps[1]),
        .bus_select_strap_c(straps[2]), .byte_order_strap(straps[3]),
        .panel_power_polarity_strap(straps[4]), .bus_start_strap_n(bs_n),
        .bus(host_bus_if_i), .panel_power_control(ppc),
        .config_valid(cfg_ok), .host_bus_mode(hmode), .big_endian(big_endian));
    chip_select_host chip_select_host_i (
        .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .bus(host_bus_if_i));
    host_bus_props host_bus_props_i (
        .aclk(aclk), .aresetn(aresetn), .addr(host_bus_if_i.addr),
        .host_data(host_bus_if_i.host_data),
        .dev_data_oe_n(host_bus_if_i.dev_data_oe_n),
        .chip_select_n(host_bus_if_i.chip_select_n),
        .low_byte_write_n(host_bus_if_i.low_byte_write_n),
        .high_byte_write_n(host_bus_if_i.high_byte_write_n),
        .read_n(host_bus_if_i.read_n), .wait_high(host_bus_if_i.wait_high));

    always #50 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic timeout();
        miscompares++;
        $display("unexpected at %0t: no answer", $time);
        test_done();
    endtask

    // Write channels released as each is taken; response held ready
    task automatic axi_write(input logic [31:0] a, d, output logic [1:0] r);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 20);
        if (n >= 20) timeout();
        r = bresp;
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 20);
        if (n >= 20) timeout();
        d = rdata;
        r = rresp;
    endtask

    // One device access: target, data, go, then poll status
    task automatic bus_op(input logic [31:0] tgt, dat, ctl,
                          output logic [31:0] st);
        logic [1:0] r;
        int         n;
        n = 0;
        axi_write(32'h0, tgt, r);
        axi_write(32'h4, dat, r);
        axi_write(32'h8, ctl, r);
        do begin
            axi_read(32'hc, st, r);
            n++;
        end while (st[STAT_DONE] !== 1'b1 && st[STAT_MISS] !== 1'b1 && n < 20);
        if (n >= 20) timeout();
    endtask

    // Straps settle before release; capture waits past the sync flops
    task automatic do_reset(input logic [4:0] s, input logic bs);
        straps  <= s;
        bs_n    <= bs;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    task automatic t_straps();
        bus_mode_t want [8] = '{mode_fast_a, mode_fast_b, mode_reserved,
            mode_word_a, mode_reserved, mode_word_b, mode_reserved,
            mode_generic_one};
        do_reset(5'h07, 1'b0);
        check({big_endian, ppc}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            do_reset({2'b11, i[2:0]}, i[3]);
            check(32'(cfg_ok), 32'(!(i[2:0] inside {2, 4, 6})));
            check(32'(hmode),
                  32'(i == 15 ? mode_generic_two : want[i[2:0]]));
        end
        do_reset(5'h1f, 1'b0);
        straps <= 5'h02;
        repeat (4) @(posedge aclk);
        check({cfg_ok, big_endian, ppc}, 32'h6);
    endtask

    task automatic t_rev();
        logic [31:0] st;
        logic [31:0] tgt [3] = '{32'h0040ffe0, 32'h0040ffe0, 32'h007fffe0};
        foreach (tgt[k]) begin
            bus_op(tgt[k], 32'h0, 32'h1, st);
            check({st[31:24], st[2:0]}, {REV, 3'b010});
        end
    endtask

    task automatic t_map();
        logic [31:0] st;
        bus_op(32'h00800000, 32'h0, 32'h1, st);
        check(32'(st[2:0]), 32'h4);
        bus_op(32'h00409ffe, 32'h1234, 32'hf, st);
        bus_op(32'h00409ffe, 32'h0, 32'h1, st);
        check(32'(st[31:16]), 32'h1234);
        bus_op(32'h0040a000, 32'h5678, 32'hf, st);
        bus_op(32'h0040a000, 32'h0, 32'h1, st);
        check(32'(st[31:16]), 32'h0);
        // Low lane alone: in big endian it carries the odd byte, reg 3
        bus_op(32'h0040ffe2, 32'h0001, 32'h7, st);
        check(32'(ppc), 32'h1);
    endtask

    // Unmapped and read-only host registers refuse
    task automatic t_axi();
        logic [1:0]  r;
        logic [31:0] d;
        axi_write(32'h10, 32'h0, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(32'hc, 32'h0, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(32'h10, d, r);
        check({d[29:0], r}, 32'(RESP_SLVERR));
    endtask

    initial begin
        t_straps();
        t_rev();
        t_map();
        t_axi();
        test_done();
    end
endmodule
`default_nettype wire
